// ===== clock_unit.sv
// calendar / binary clock unit with alarm, periodic, carry and capture events
// assumes SUBCLOCK_IN_I (32768 Hz) and CAPTURE_I are synchronous to SYS_CLK_I
`timescale 1ns/1ps
`default_nettype none

module clock_unit (
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic SRST_I,
	// register port
	input wire clock_unit_pkg::reg_req_t REG_REQ_I,
	output logic [7:0] RDATA_O,
	// pins
	input wire logic SUBCLOCK_IN_I,
	input wire logic CAPTURE_I,
	output logic SECOND_PULSE_OUT_O,
	output logic PERIOD_EVT_O,
	// events
	output logic IRQ_O,
	output logic WAKE_O
);

	// ************************************
	// helpers
	// ************************************
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcd_inc

	function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
			(yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
		case (mon)
			8'h02: month_last = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
			default: month_last = 8'h31;
		endcase
	endfunction : month_last

	function automatic logic hit(input logic [5:0] a, input logic [5:0] base, input logic [5:0] n);
		hit = (a >= base) && (a < base + n);
	endfunction : hit

	// ************************************
	// state
	// ************************************
	logic [7:0] ctrl_one_q, ctrl_two_q, ctrl_three_q, ctrl_four_q, corr_q;
	logic [3:0] irq_stat_q, irq_mask_q;
	logic [7:0] cal_q [clock_unit_pkg::N_CAL];
	logic [7:0] alm_q [clock_unit_pkg::N_CAL];
	logic [7:0] alm_en_q;
	logic [31:0] bin_q, bin_alm_q, bin_alm_en_q;
	logic [7:0] cap_q [clock_unit_pkg::N_CAP];
	logic [31:0] cap_bin_q;
	logic [6:0] pre_q;
	logic [7:0] sub_q;
	logic sclk_prev_q, cap_prev_q, sec_tick_q, match_prev_q;
	logic [7:0] rdata_q;
	logic out_q, prd_evt_q;

	logic [5:0] addr;
	logic wr, rd;
	logic running, binary, h24, sclk_edge, tick, sec_tick, adj_up, adj_any, min_carry;
	logic hour_carry, day_carry, mon_carry, prd_evt, cap_edge, sub_read_clash, match;
	logic [3:0] prd_sel;
	logic [7:0] prd_mask;
	logic [7:0] hr12_next;

	assign addr = REG_REQ_I.addr;
	assign wr = REG_REQ_I.wr;
	assign rd = REG_REQ_I.rd;
	assign running = ctrl_three_q[clock_unit_pkg::F_THREE_EN];
	assign binary = ctrl_two_q[clock_unit_pkg::F_TWO_MODE];
	assign h24 = ctrl_two_q[clock_unit_pkg::F_TWO_H24];
	assign adj_any = wr && addr == clock_unit_pkg::A_CTRL_TWO && REG_REQ_I.wdata[clock_unit_pkg::F_TWO_ADJ30];
	assign adj_up = adj_any && !binary && cal_q[clock_unit_pkg::C_SEC] >= 8'h30;

	// ************************************
	// prescaler and sub-second counter
	// ************************************
	// sub_q counts at 256 Hz; bit 0 is the 128 Hz step, bits 7:1 weigh 64 Hz .. 1 Hz
	assign sclk_edge = SUBCLOCK_IN_I && !sclk_prev_q;
	assign tick = running && sclk_edge && pre_q == clock_unit_pkg::PRESCALE_LAST;
	assign sec_tick = tick && sub_q == clock_unit_pkg::SUBSEC_LAST;

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			sclk_prev_q <= 1'b0;
			pre_q <= 7'h00;
			sub_q <= 8'h00;
		end else begin
			sclk_prev_q <= SUBCLOCK_IN_I;
			if (running && sclk_edge) begin
				pre_q <= pre_q + 7'h01;
			end
			// trim at each minute carry (each second in binary mode while the seconds field holds 59) except a 30-second adjust one;
			// only moves the prescaler, so the visible count never skips
			if (min_carry && corr_q[clock_unit_pkg::F_CORR_EN]) begin
				if (corr_q[clock_unit_pkg::F_CORR_SUB]) begin
					pre_q <= pre_q - {1'b0, corr_q[5:0]};
				end else begin
					pre_q <= pre_q + {1'b0, corr_q[5:0]};
				end
			end
			if (tick) begin
				sub_q <= sub_q + 8'h01;
			end
			if (adj_any) begin
				pre_q <= 7'h00;
				sub_q <= 8'h00;
			end
		end
	end

	// ************************************
	// calendar and binary counters
	// ************************************
	assign min_carry = (sec_tick && cal_q[clock_unit_pkg::C_SEC] == 8'h59) || adj_up;
	assign hour_carry = min_carry && cal_q[clock_unit_pkg::C_MIN] == 8'h59;
	assign day_carry = hour_carry && (h24 ? cal_q[clock_unit_pkg::C_HOUR] == 8'h23 :
		cal_q[clock_unit_pkg::C_HOUR] == 8'h31);
	assign mon_carry = day_carry && cal_q[clock_unit_pkg::C_DATE] ==
		month_last(cal_q[clock_unit_pkg::C_MON], cal_q[clock_unit_pkg::C_YEAR]);

	// 12-hour: 12, 01 .. 11 with pm flag in bit 5; 11 -> 12 flips the flag
	always_comb begin
		hr12_next = cal_q[clock_unit_pkg::C_HOUR];
		case (cal_q[clock_unit_pkg::C_HOUR][4:0])
			5'h11: hr12_next = {2'b00, ~cal_q[clock_unit_pkg::C_HOUR][clock_unit_pkg::F_HOUR_PM], 5'h12};
			5'h12: hr12_next = {2'b00, cal_q[clock_unit_pkg::C_HOUR][clock_unit_pkg::F_HOUR_PM], 5'h01};
			default: hr12_next = bcd_inc(cal_q[clock_unit_pkg::C_HOUR]);
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			for (int i = 0; i < clock_unit_pkg::N_CAL; i++) begin
				cal_q[i] <= 8'h00;
			end
			cal_q[clock_unit_pkg::C_DATE] <= clock_unit_pkg::DATE_RST;
			cal_q[clock_unit_pkg::C_MON] <= clock_unit_pkg::DATE_RST;
		end else begin
			if (!binary) begin
				if (sec_tick || adj_any) begin
					cal_q[clock_unit_pkg::C_SEC] <= (min_carry || adj_any) ? 8'h00 :
						bcd_inc(cal_q[clock_unit_pkg::C_SEC]);
				end
				if (min_carry) begin
					cal_q[clock_unit_pkg::C_MIN] <= hour_carry ? 8'h00 : bcd_inc(cal_q[clock_unit_pkg::C_MIN]);
				end
				if (hour_carry) begin
					if (h24) begin
						cal_q[clock_unit_pkg::C_HOUR] <= day_carry ? 8'h00 :
							bcd_inc(cal_q[clock_unit_pkg::C_HOUR]);
					end else begin
						cal_q[clock_unit_pkg::C_HOUR] <= hr12_next;
					end
				end
				if (day_carry) begin
					cal_q[clock_unit_pkg::C_WDAY] <= cal_q[clock_unit_pkg::C_WDAY] == 8'h06 ? 8'h00 :
						cal_q[clock_unit_pkg::C_WDAY] + 8'h01;
					cal_q[clock_unit_pkg::C_DATE] <= mon_carry ? 8'h01 : bcd_inc(cal_q[clock_unit_pkg::C_DATE]);
				end
				if (mon_carry) begin
					cal_q[clock_unit_pkg::C_MON] <= cal_q[clock_unit_pkg::C_MON] == 8'h12 ? 8'h01 :
						bcd_inc(cal_q[clock_unit_pkg::C_MON]);
					if (cal_q[clock_unit_pkg::C_MON] == 8'h12) begin
						cal_q[clock_unit_pkg::C_YEAR] <= cal_q[clock_unit_pkg::C_YEAR] == 8'h99 ? 8'h00 :
							bcd_inc(cal_q[clock_unit_pkg::C_YEAR]);
					end
				end
			end
			// software write wins over the count for that field only
			if (wr && hit(addr, clock_unit_pkg::A_CAL_BASE, 6'd7)) begin
				cal_q[3'(addr - clock_unit_pkg::A_CAL_BASE)] <= REG_REQ_I.wdata;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			bin_q <= 32'h0000_0000;
		end else begin
			if (binary && sec_tick) begin
				bin_q <= bin_q + 32'h0000_0001;
			end
			if (wr && hit(addr, clock_unit_pkg::A_BIN_CNT, 6'd4)) begin
				bin_q[8*addr[1:0] +: 8] <= REG_REQ_I.wdata;
			end
		end
	end

	// ************************************
	// alarm compare
	// ************************************
	logic [clock_unit_pkg::N_CAL-1:0] field_ok;
	generate
		for (genvar g = 0; g < clock_unit_pkg::N_CAL; g++) begin : g_alm
			assign field_ok[g] = !alm_en_q[g] || cal_q[g] == alm_q[g];
		end
	endgenerate

	always_comb begin
		if (binary) begin
			match = (|bin_alm_en_q) && ((bin_q ^ bin_alm_q) & bin_alm_en_q) == 32'h0000_0000;
		end else begin
			match = (|alm_en_q[clock_unit_pkg::N_CAL-1:0]) && (&field_ok);
		end
	end

	// ************************************
	// periodic, capture, clock out
	// ************************************
	// code 1..9 is 2^(code-9) s, code 10 is 2 s, 0 is off
	assign prd_sel = ctrl_one_q[clock_unit_pkg::F_ONE_PRD_LO +: 4];
	assign prd_mask = (prd_sel >= 4'h9) ? 8'hFF : 8'((9'h001 << (prd_sel - 4'h1)) - 9'h001);
	assign prd_evt = tick && prd_sel != 4'h0 && prd_sel <= clock_unit_pkg::PRD_TWO_SEC &&
		(sub_q & prd_mask) == prd_mask &&
		(prd_sel != clock_unit_pkg::PRD_TWO_SEC || (binary ? bin_q[0] : cal_q[clock_unit_pkg::C_SEC][0]));
	assign cap_edge = ctrl_four_q[clock_unit_pkg::F_FOUR_CAP_EN] &&
		((ctrl_four_q[0] && CAPTURE_I && !cap_prev_q) || (ctrl_four_q[1] && !CAPTURE_I && cap_prev_q));
	assign sub_read_clash = rd && addr == clock_unit_pkg::A_SUBSEC && tick && sub_q[0];

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			cap_prev_q <= 1'b0;
			cap_bin_q <= 32'h0000_0000;
			for (int i = 0; i < clock_unit_pkg::N_CAP; i++) begin
				cap_q[i] <= 8'h00;
			end
		end else begin
			cap_prev_q <= CAPTURE_I;
			if (cap_edge) begin
				if (binary) begin
					cap_bin_q <= bin_q;
				end else begin
					cap_q[0] <= cal_q[clock_unit_pkg::C_SEC];
					cap_q[1] <= cal_q[clock_unit_pkg::C_MIN];
					cap_q[2] <= cal_q[clock_unit_pkg::C_HOUR];
					cap_q[3] <= cal_q[clock_unit_pkg::C_DATE];
					cap_q[4] <= cal_q[clock_unit_pkg::C_MON];
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			out_q <= 1'b0;
			prd_evt_q <= 1'b0;
		end else begin
			out_q <= ctrl_one_q[clock_unit_pkg::F_ONE_OUT_EN] &&
				(ctrl_one_q[clock_unit_pkg::F_ONE_FREQ_SEL] ? sub_q[1] : sub_q[7]);
			prd_evt_q <= prd_evt;
		end
	end

	// ************************************
	// interrupt status
	// ************************************
	logic [3:0] irq_set;
	assign irq_set = {cap_edge, sec_tick || sub_read_clash, prd_evt, sec_tick_q && match && !match_prev_q};

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			irq_stat_q <= 4'h0;
			sec_tick_q <= 1'b0;
			match_prev_q <= 1'b0;
		end else begin
			sec_tick_q <= sec_tick || adj_any;
			if (sec_tick_q) begin
				match_prev_q <= match;
			end
			// a new event in the clearing cycle survives
			irq_stat_q <= (irq_stat_q & ~((wr && addr == clock_unit_pkg::A_IRQ_STAT) ?
				REG_REQ_I.wdata[3:0] : 4'h0)) | irq_set;
		end
	end

	assign IRQ_O = |(irq_stat_q & irq_mask_q);
	// counting never stops for standby; only alarm and periodic may wake
	assign WAKE_O = ctrl_one_q[clock_unit_pkg::F_ONE_WAKE_EN] &&
		|(irq_stat_q[clock_unit_pkg::IRQ_PERIOD:clock_unit_pkg::IRQ_ALARM] &
		irq_mask_q[clock_unit_pkg::IRQ_PERIOD:clock_unit_pkg::IRQ_ALARM]);
	assign SECOND_PULSE_OUT_O = out_q;
	assign PERIOD_EVT_O = prd_evt_q;

	// ************************************
	// control registers
	// ************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			ctrl_one_q <= clock_unit_pkg::CTRL_ONE_RST;
			ctrl_two_q <= clock_unit_pkg::CTRL_TWO_RST;
			ctrl_three_q <= 8'h00;
			ctrl_four_q <= clock_unit_pkg::CTRL_FOUR_RST;
			corr_q <= 8'h00;
			irq_mask_q <= 4'h0;
			alm_en_q <= 8'h00;
			bin_alm_q <= 32'h0000_0000;
			bin_alm_en_q <= 32'h0000_0000;
			for (int i = 0; i < clock_unit_pkg::N_CAL; i++) begin
				alm_q[i] <= 8'h00;
			end
		end else if (wr) begin
			case (addr)
				clock_unit_pkg::A_CTRL_ONE: ctrl_one_q <= {1'b0, REG_REQ_I.wdata[6:0]};
				clock_unit_pkg::A_CTRL_TWO: ctrl_two_q <= {6'h00, REG_REQ_I.wdata[1:0]};
				clock_unit_pkg::A_CTRL_THREE: ctrl_three_q <= {7'h00, REG_REQ_I.wdata[0]};
				clock_unit_pkg::A_CTRL_FOUR: ctrl_four_q <= {5'h00, REG_REQ_I.wdata[2:0]};
				clock_unit_pkg::A_CORR: corr_q <= REG_REQ_I.wdata;
				clock_unit_pkg::A_IRQ_MASK: irq_mask_q <= REG_REQ_I.wdata[3:0];
				clock_unit_pkg::A_CAL_ALM_EN: alm_en_q <= {1'b0, REG_REQ_I.wdata[6:0]};
				default: begin
					if (hit(addr, clock_unit_pkg::A_CAL_ALM_BASE, 6'd7)) begin
						alm_q[3'(addr - clock_unit_pkg::A_CAL_ALM_BASE)] <= REG_REQ_I.wdata;
					end
					if (hit(addr, clock_unit_pkg::A_BIN_ALM, 6'd4)) begin
						bin_alm_q[8*addr[1:0] +: 8] <= REG_REQ_I.wdata;
					end
					if (hit(addr, clock_unit_pkg::A_BIN_ALM_EN, 6'd4)) begin
						bin_alm_en_q[8*addr[1:0] +: 8] <= REG_REQ_I.wdata;
					end
				end
			endcase
		end
	end

	// ************************************
	// read port
	// ************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			rdata_q <= 8'h00;
		end else if (!rd) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= 8'h00;
			case (addr)
				clock_unit_pkg::A_SUBSEC: rdata_q <= {1'b0, sub_q[7:1]};
				clock_unit_pkg::A_CAL_ALM_EN: rdata_q <= alm_en_q;
				clock_unit_pkg::A_CTRL_ONE: rdata_q <= ctrl_one_q;
				clock_unit_pkg::A_CTRL_TWO: rdata_q <= ctrl_two_q;
				clock_unit_pkg::A_CTRL_THREE: rdata_q <= ctrl_three_q;
				clock_unit_pkg::A_CTRL_FOUR: rdata_q <= ctrl_four_q;
				clock_unit_pkg::A_CORR: rdata_q <= corr_q;
				clock_unit_pkg::A_IRQ_STAT: rdata_q <= {4'h0, irq_stat_q};
				clock_unit_pkg::A_IRQ_MASK: rdata_q <= {4'h0, irq_mask_q};
				default: begin
					if (hit(addr, clock_unit_pkg::A_CAL_BASE, 6'd7)) begin
						rdata_q <= cal_q[3'(addr - clock_unit_pkg::A_CAL_BASE)];
					end
					if (hit(addr, clock_unit_pkg::A_CAL_ALM_BASE, 6'd7)) begin
						rdata_q <= alm_q[3'(addr - clock_unit_pkg::A_CAL_ALM_BASE)];
					end
					if (hit(addr, clock_unit_pkg::A_BIN_CNT, 6'd4)) begin
						rdata_q <= bin_q[8*addr[1:0] +: 8];
					end
					if (hit(addr, clock_unit_pkg::A_BIN_ALM, 6'd4)) begin
						rdata_q <= bin_alm_q[8*addr[1:0] +: 8];
					end
					if (hit(addr, clock_unit_pkg::A_BIN_ALM_EN, 6'd4)) begin
						rdata_q <= bin_alm_en_q[8*addr[1:0] +: 8];
					end
					if (hit(addr, clock_unit_pkg::A_CAP_CAL, 6'd5)) begin
						rdata_q <= cap_q[3'(addr - clock_unit_pkg::A_CAP_CAL)];
					end
					if (hit(addr, clock_unit_pkg::A_CAP_BIN, 6'd4)) begin
						rdata_q <= cap_bin_q[8*addr[1:0] +: 8];
					end
				end
			endcase
		end
	end

	assign RDATA_O = rdata_q;

endmodule : clock_unit

`default_nettype wire

// ===== clock_unit_pkg.sv
// constants, field layouts and bus carrier for the calendar/binary clock unit
// assumes one system clock and a register port with 6-bit byte addresses

package clock_unit_pkg;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// ************************************
	// register offsets
	// ************************************
	localparam logic [5:0] A_SUBSEC = 6'h00;
	localparam logic [5:0] A_CAL_BASE = 6'h01;
	localparam logic [5:0] A_CAL_ALM_BASE = 6'h08;
	localparam logic [5:0] A_CAL_ALM_EN = 6'h0F;
	localparam logic [5:0] A_CTRL_ONE = 6'h10;
	localparam logic [5:0] A_CTRL_TWO = 6'h11;
	localparam logic [5:0] A_CTRL_THREE = 6'h12;
	localparam logic [5:0] A_CTRL_FOUR = 6'h13;
	localparam logic [5:0] A_CORR = 6'h14;
	localparam logic [5:0] A_IRQ_STAT = 6'h15;
	localparam logic [5:0] A_IRQ_MASK = 6'h16;
	localparam logic [5:0] A_BIN_CNT = 6'h18;
	localparam logic [5:0] A_BIN_ALM = 6'h1C;
	localparam logic [5:0] A_BIN_ALM_EN = 6'h20;
	localparam logic [5:0] A_CAP_CAL = 6'h24;
	localparam logic [5:0] A_CAP_BIN = 6'h2C;

	// ************************************
	// field positions
	// ************************************
	localparam int F_ONE_OUT_EN = 0;
	localparam int F_ONE_FREQ_SEL = 1;
	localparam int F_ONE_PRD_LO = 2;
	localparam int F_ONE_WAKE_EN = 6;
	localparam int F_TWO_MODE = 0;
	localparam int F_TWO_H24 = 1;
	localparam int F_TWO_ADJ30 = 2;
	localparam int F_THREE_EN = 0;
	localparam int F_FOUR_CAP_EN = 2;
	localparam int F_CORR_EN = 6;
	localparam int F_CORR_SUB = 7;
	localparam int F_HOUR_PM = 5;
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_PERIOD = 1;
	localparam int IRQ_CARRY = 2;
	localparam int IRQ_CAPTURE = 3;

	// calendar field index
	localparam int C_SEC = 0;
	localparam int C_MIN = 1;
	localparam int C_HOUR = 2;
	localparam int C_WDAY = 3;
	localparam int C_DATE = 4;
	localparam int C_MON = 5;
	localparam int C_YEAR = 6;
	localparam int N_CAL = 7;
	localparam int N_CAP = 5;

	// ************************************
	// reset values and counts
	// ************************************
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h02;
	localparam logic [7:0] CTRL_FOUR_RST = 8'h00;
	localparam logic [7:0] DATE_RST = 8'h01;
	localparam logic [6:0] PRESCALE_LAST = 7'h7F;
	localparam logic [7:0] SUBSEC_LAST = 8'hFF;
	localparam logic [3:0] PRD_TWO_SEC = 4'hA;

endpackage : clock_unit_pkg

// ===== clock_unit_properties.sv
// concurrent checks on the clock unit's register port, pins and event outputs
// assumes it is bound onto clock_unit and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none

module clock_unit_properties (
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic SRST_I,
	// register port
	input wire clock_unit_pkg::reg_req_t REG_REQ_I,
	input wire logic [7:0] RDATA_O,
	// pins
	input wire logic SUBCLOCK_IN_I,
	input wire logic CAPTURE_I,
	input wire logic SECOND_PULSE_OUT_O,
	input wire logic PERIOD_EVT_O,
	// events
	input wire logic IRQ_O,
	input wire logic WAKE_O
);

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SRST_I);

	// ****************************
	// helper logic
	// ****************************
	// cycles since the last periodic pulse, saturating so a long idle never wraps
	logic [8:0] gap_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			gap_q <= 9'h1FF;
		end else if (PERIOD_EVT_O) begin
			gap_q <= 9'h000;
		end else if (gap_q != 9'h1FF) begin
			gap_q <= gap_q + 9'h001;
		end
	end

	sequence s_rd_at(a);
		REG_REQ_I.rd && REG_REQ_I.addr == a;
	endsequence
	sequence s_wr_at(a);
		REG_REQ_I.wr && REG_REQ_I.addr == a;
	endsequence
	sequence s_mask_off;
		s_wr_at(clock_unit_pkg::A_IRQ_MASK) ##0 REG_REQ_I.wdata == 8'h00;
	endsequence
	sequence s_wake_off;
		s_wr_at(clock_unit_pkg::A_CTRL_ONE) ##0 !REG_REQ_I.wdata[clock_unit_pkg::F_ONE_WAKE_EN];
	endsequence
	sequence s_out_off;
		s_wr_at(clock_unit_pkg::A_CTRL_ONE) ##0 !REG_REQ_I.wdata[clock_unit_pkg::F_ONE_OUT_EN];
	endsequence

	// ****************************
	// assertions
	// ****************************
	rd_idle_zero_a:
	assert property (!REG_REQ_I.rd |=> RDATA_O == 8'h00) else $error("read data not zero outside a read answer");
	unmapped_read_a:
	assert property ((s_rd_at(6'h3F) or s_rd_at(6'h17)) |=> RDATA_O == 8'h00) else $error("unmapped read not zero");
	adjust_reads_zero_a:
	assert property (s_rd_at(clock_unit_pkg::A_CTRL_TWO) |=> !RDATA_O[clock_unit_pkg::F_TWO_ADJ30])
		else $error("adjust request bit reads back set");
	subsec_top_zero_a:
	assert property (s_rd_at(clock_unit_pkg::A_SUBSEC) |=> !RDATA_O[7]) else $error("sub-second top bit set");
	period_gap_a:
	assert property (PERIOD_EVT_O |-> gap_q >= 9'h0FF) else $error("periodic pulses closer than 1/256 s");
	period_pulse_a:
	assert property ($rose(PERIOD_EVT_O) |=> $fell(PERIOD_EVT_O)) else $error("periodic pulse longer than one cycle");
	mask_clear_a:
	assert property (s_mask_off |=> !IRQ_O) else $error("interrupt high with all sources masked");
	wake_needs_irq_a:
	assert property (WAKE_O |-> IRQ_O) else $error("wake without an unmasked interrupt");
	wake_off_a:
	assert property (s_wake_off |=> !WAKE_O) else $error("wake high with wake disabled");
	clkout_off_a:
	assert property (s_out_off |-> ##3 !SECOND_PULSE_OUT_O) else $error("clock output runs while disabled");
	clkout_hold_a:
	assert property ($rose(SECOND_PULSE_OUT_O) |=> SECOND_PULSE_OUT_O [*8]) else $error("clock output glitch");

endmodule : clock_unit_properties

bind clock_unit clock_unit_properties u_props (
	.SYS_CLK_I(SYS_CLK_I),
	.SRST_I(SRST_I),
	.REG_REQ_I(REG_REQ_I),
	.RDATA_O(RDATA_O),
	.SUBCLOCK_IN_I(SUBCLOCK_IN_I),
	.CAPTURE_I(CAPTURE_I),
	.SECOND_PULSE_OUT_O(SECOND_PULSE_OUT_O),
	.PERIOD_EVT_O(PERIOD_EVT_O),
	.IRQ_O(IRQ_O),
	.WAKE_O(WAKE_O)
);

`default_nettype wire

// ===== clock_unit_tb.sv
// self-checking bench for the clock unit: register tasks, sub-clock and capture drive
// assumes clock_unit_pkg and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end

module clock_unit_tb;

	logic clk;
	logic srst;
	clock_unit_pkg::reg_req_t req;
	logic [7:0] rdata;
	logic sub_run;
	logic sub_clk = 1'b0;
	logic cap;
	logic spo;
	logic pev;
	logic irq;
	logic wake;
	int fail_count;
	int n_checks;
	int n;
	logic [31:0] bin_v = 32'h1234_5678;
	logic [5:0] rst_a [12] = '{6'h01, 6'h05, 6'h06, 6'h07, 6'h10, 6'h11, 6'h12, 6'h13, 6'h15, 6'h16, 6'h17, 6'h3F};
	logic [7:0] rst_e [12] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// 11:59:59 pm, weekday 6, 28 feb of a leap year, 12-hour mode
	logic [7:0] cal_set [7] = '{8'h59, 8'h59, 8'h31, 8'h06, 8'h28, 8'h02, 8'h24};
	logic [7:0] cal_exp [7] = '{8'h00, 8'h00, 8'h12, 8'h00, 8'h29, 8'h02, 8'h24};
	logic [7:0] cap_exp [5] = '{8'h00, 8'h00, 8'h12, 8'h29, 8'h02};

	clock_unit u_dut (
		.SYS_CLK_I(clk),
		.SRST_I(srst),
		.REG_REQ_I(req),
		.RDATA_O(rdata),
		.SUBCLOCK_IN_I(sub_clk),
		.CAPTURE_I(cap),
		.SECOND_PULSE_OUT_O(spo),
		.PERIOD_EVT_O(pev),
		.IRQ_O(irq),
		.WAKE_O(wake)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// fastest legal sub-clock: one rising edge every two system cycles
	always @(posedge clk) begin
		sub_clk <= sub_run & ~sub_clk;
	end

	// ****************************
	// tasks
	// ****************************
	task end_of_test;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	task wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
		#1;
	endtask : wr

	task rchk(input logic [5:0] a, input logic [7:0] e);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		#1;
		`CHK(rdata, e)
	endtask : rchk

	// sel 0: cycles to next periodic pulse; sel 1: cycles to next clock-output change
	task measure(input bit sel, output int cnt);
		logic last;
		last = spo;
		for (cnt = 1; cnt < 5000; cnt++) begin
			@(posedge clk);
			#1;
			if (sel ? (spo !== last) : (pev === 1'b1)) begin
				break;
			end
		end
		if (cnt >= 5000) begin
			fail_count++;
			end_of_test();
		end
	endtask : measure

	// ****************************
	// main sequence
	// ****************************
	initial begin
		srst = 1'b1;
		req = '0;
		sub_run = 1'b0;
		cap = 1'b0;
		fail_count = 0;
		n_checks = 0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 12; i++) rchk(rst_a[i], rst_e[i]);
		// disabled unit must ignore sub-clock edges
		@(posedge clk) sub_run <= 1'b1;
		repeat (1024) @(posedge clk);
		sub_run <= 1'b0;
		rchk(6'h00, 8'h00);
		// one full second across midnight and the leap day
		wr(6'h11, 8'h00);
		for (int i = 0; i < 7; i++) wr(6'(1 + i), cal_set[i]);
		wr(6'h08, 8'h00);
		wr(6'h0F, 8'h01);
		wr(6'h16, 8'h0F);
		wr(6'h14, 8'h7F);
		wr(6'h12, 8'h01);
		@(posedge clk) sub_run <= 1'b1;
		repeat (66000) @(posedge clk);
		sub_run <= 1'b0;
		// full-scale trim at the minute carry: two ticks land after the second instead of one
		rchk(6'h00, 8'h01);
		for (int i = 0; i < 7; i++) rchk(6'(1 + i), cal_exp[i]);
		rchk(6'h15, 8'h05);
		`CHK(irq, 1'b1)
		wr(6'h15, 8'h05);
		rchk(6'h15, 8'h00);
		// calendar capture on a rising pin edge
		wr(6'h13, 8'h05);
		@(posedge clk) cap <= 1'b1;
		for (int i = 0; i < 5; i++) rchk(6'(8'h24 + i), cap_exp[i]);
		rchk(6'h15, 8'h08);
		// 30-second adjust both ways, 24-hour mode
		wr(6'h11, 8'h02);
		wr(6'h01, 8'h29);
		wr(6'h02, 8'h12);
		wr(6'h11, 8'h06);
		rchk(6'h01, 8'h00);
		rchk(6'h02, 8'h12);
		wr(6'h01, 8'h30);
		wr(6'h11, 8'h06);
		rchk(6'h01, 8'h00);
		rchk(6'h02, 8'h13);
		rchk(6'h11, 8'h02);
		// four 256 Hz ticks from a cleared sub-second count
		@(posedge clk) sub_run <= 1'b1;
		repeat (1024) @(posedge clk);
		sub_run <= 1'b0;
		rchk(6'h00, 8'h02);
		// back-to-back sub-second reads must collide with a change
		wr(6'h15, 8'h0F);
		@(posedge clk) sub_run <= 1'b1;
		repeat (600) begin
			@(posedge clk) req <= '{addr: 6'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		end
		@(posedge clk) req <= '0;
		sub_run <= 1'b0;
		rchk(6'h15, 8'h04);
		// periodic codes 1..3, wake enabled
		wr(6'h16, 8'h02);
		@(posedge clk) sub_run <= 1'b1;
		for (int c = 1; c < 4; c++) begin
			wr(6'h10, 8'(8'h40 + 4 * c));
			measure(1'b0, n);
			measure(1'b0, n);
			`CHK(n, 256 << (c - 1))
		end
		`CHK(irq, 1'b1)
		`CHK(wake, 1'b1)
		wr(6'h16, 8'h00);
		`CHK(irq, 1'b0)
		// 64 Hz clock output: half period of two 256 Hz ticks
		wr(6'h10, 8'h03);
		measure(1'b1, n);
		measure(1'b1, n);
		`CHK(n, 512)
		// binary mode: byte order and capture on a falling edge
		@(posedge clk) sub_run <= 1'b0;
		wr(6'h11, 8'h03);
		for (int i = 0; i < 4; i++) wr(6'(8'h18 + i), bin_v[8 * i +: 8]);
		for (int i = 0; i < 4; i++) rchk(6'(8'h18 + i), bin_v[8 * i +: 8]);
		wr(6'h13, 8'h06);
		@(posedge clk) cap <= 1'b0;
		for (int i = 0; i < 4; i++) rchk(6'(8'h2C + i), bin_v[8 * i +: 8]);
		// binary alarm: bit 0 differs until its enable is dropped; the adjust strobe re-evaluates at once
		for (int i = 0; i < 4; i++) wr(6'(8'h1C + i), bin_v[8 * i +: 8]);
		wr(6'h1C, 8'h79);
		for (int i = 0; i < 4; i++) wr(6'(8'h20 + i), 8'hFF);
		wr(6'h15, 8'h0F);
		wr(6'h11, 8'h07);
		rchk(6'h15, 8'h00);
		wr(6'h20, 8'hFE);
		wr(6'h11, 8'h07);
		rchk(6'h15, 8'h01);
		end_of_test();
	end

endmodule : clock_unit_tb

`default_nettype wire
